// File: shared/e3m_consts.svh
`ifndef E3M_CONSTS_SVH
`define E3M_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define E3M_ADDR_W           16
`define E3M_ADDR_OPMODE      16'h1100
`define E3M_ADDR_DEFECT      16'h1111
`define E3M_ADDR_INT_STAT    16'h1114
`define E3M_ADDR_INT_MASK    16'h1115

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define E3M_OPMODE_RST       8'h0b
`define E3M_INT_MASK_RST     8'h03
`define E3M_LOF_ALGO_RST     1'h0

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define E3M_OPM_DS3_SEL      6
`define E3M_OPM_INT_LOS_EN   5
`define E3M_OPM_FRAME_FMT    2
`define E3M_DEF_LOF_ALGO     7
`define E3M_DEF_LOF          6
`define E3M_DEF_OOF          5
`define E3M_DEF_LOS          4
`define E3M_DEF_AIS          3
`define E3M_DEF_RDI          0
`define E3M_INT_AIS          0
`define E3M_INT_LOS          1
`define E3M_INT_NUM          2

// ---------------------------------------------------------------------------
// Line criteria
// ---------------------------------------------------------------------------
`define E3M_FRAME_BITS       11'd1536
`define E3M_LOS_ZEROS        6'd32
`define E3M_LOS_CLEAN_BITS   6'd32
`define E3M_LOS_ZERO_STRING  6'd4
`define E3M_AIS_DECL_MAX     5'd7
`define E3M_AIS_CLR_MIN      4'd8

`endif

// File: shared/e3m_pkg.sv
package e3m_pkg;

  typedef enum logic {
    e3m_los_clear,
    e3m_los_declared
  } e3m_los_state_e;

  typedef enum logic {
    e3m_ais_clear,
    e3m_ais_declared
  } e3m_ais_state_e;

  typedef enum logic [1:0] {
    e3m_sel_none,
    e3m_sel_opmode,
    e3m_sel_defect,
    e3m_sel_int_stat
  } e3m_reg_sel_e;

endpackage

// File: shared/e3m_bit_if.sv
`timescale 1ns/1ns
`default_nettype none

// Recovered line bits as seen on the system clock.
interface e3m_bit_if;
  logic bit_valid;
  logic bit_data;
  logic frame_end;

  modport src (output bit_valid, output bit_data, output frame_end);
  modport snk (input bit_valid, input bit_data, input frame_end);
endinterface

`default_nettype wire

// File: rtl/e3m_los_det.sv
`timescale 1ns/1ns
`default_nettype none
`include "e3m_consts.svh"

module e3m_los_det (
  input  wire logic   mclk,
  input  wire logic   rst,
  e3m_bit_if.snk      bits,
  input  wire logic   int_los_en,
  input  wire logic   liu_los,
  output logic        los_defect
);

  e3m_pkg::e3m_los_state_e state_r;
  logic [5:0]              zero_run_r;
  logic [5:0]              clean_cnt_r;

  // Zeros in a row, saturating at the declare threshold.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      zero_run_r <= 6'h00;
    end else if (bits.bit_valid) begin
      if (bits.bit_data) begin
        zero_run_r <= 6'h00;
      end else if (zero_run_r != `E3M_LOS_ZEROS) begin
        zero_run_r <= zero_run_r + 6'h01;
      end
    end
  end

  // Bits since the last string of four zeros, counted while declared.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clean_cnt_r <= 6'h00;
    end else if (state_r == e3m_pkg::e3m_los_clear) begin
      clean_cnt_r <= 6'h00;
    end else if (bits.bit_valid) begin
      // A zero that extends a run of three or more restarts the count,
      // including runs that have saturated the zero counter.
      if (!bits.bit_data &&
          zero_run_r >= `E3M_LOS_ZERO_STRING - 6'h01) begin
        clean_cnt_r <= 6'h00;
      end else if (clean_cnt_r != `E3M_LOS_CLEAN_BITS) begin
        clean_cnt_r <= clean_cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= e3m_pkg::e3m_los_clear;
    end else begin
      unique case (state_r)
        e3m_pkg::e3m_los_clear: begin
          if ((int_los_en && zero_run_r == `E3M_LOS_ZEROS) || liu_los) begin
            state_r <= e3m_pkg::e3m_los_declared;
          end
        end
        e3m_pkg::e3m_los_declared: begin
          if (clean_cnt_r == `E3M_LOS_CLEAN_BITS && !liu_los) begin
            state_r <= e3m_pkg::e3m_los_clear;
          end
        end
      endcase
    end
  end

  assign los_defect = (state_r == e3m_pkg::e3m_los_declared);

endmodule

`default_nettype wire

// File: rtl/e3m_ais_det.sv
`timescale 1ns/1ns
`default_nettype none
`include "e3m_consts.svh"

module e3m_ais_det (
  input  wire logic   mclk,
  input  wire logic   rst,
  e3m_bit_if.snk      bits,
  input  wire logic   g751_mode,
  output logic        ais_defect
);

  e3m_pkg::e3m_ais_state_e state_r;
  logic [3:0]              zcnt_r;
  logic [3:0]              prev_r;
  logic                    have_prev_r;
  logic [3:0]              cur_cnt;
  logic [4:0]              pair_sum;

  // Zeros of the current frame including this bit, saturating at eight.
  always_comb begin
    cur_cnt = zcnt_r;
    if (bits.bit_valid && !bits.bit_data && zcnt_r != `E3M_AIS_CLR_MIN) begin
      cur_cnt = zcnt_r + 4'h1;
    end
    pair_sum = {1'b0, prev_r} + {1'b0, cur_cnt};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      zcnt_r      <= 4'h0;
      prev_r      <= 4'h0;
      have_prev_r <= 1'b0;
    end else if (bits.bit_valid && bits.frame_end) begin
      zcnt_r      <= 4'h0;
      prev_r      <= cur_cnt;
      have_prev_r <= 1'b1;
    end else begin
      zcnt_r      <= cur_cnt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= e3m_pkg::e3m_ais_clear;
    end else if (!g751_mode) begin
      state_r <= e3m_pkg::e3m_ais_clear;
    end else if (bits.bit_valid && bits.frame_end && have_prev_r) begin
      unique case (state_r)
        e3m_pkg::e3m_ais_clear: begin
          if (pair_sum <= `E3M_AIS_DECL_MAX) begin
            state_r <= e3m_pkg::e3m_ais_declared;
          end
        end
        e3m_pkg::e3m_ais_declared: begin
          if (prev_r >= `E3M_AIS_CLR_MIN && cur_cnt >= `E3M_AIS_CLR_MIN) begin
            state_r <= e3m_pkg::e3m_ais_clear;
          end
        end
      endcase
    end
  end

  assign ais_defect = (state_r == e3m_pkg::e3m_ais_declared);

endmodule

`default_nettype wire

// File: rtl/e3m_defect_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "e3m_consts.svh"

// How it works
// - LOS clearing sets change bit 1, interrupt.
// - Internal zero detector off: follow line unit.
// - Declare AIS on at most seven zeros over two frames.
// - Defect register bit 3 high while AIS.
// - AIS declare sets change bit 0, interrupt.
// - Clear AIS after two frames of eight zeros.
// - Defect register bit 3 low after AIS clears.
// - AIS clear sets change bit 0, interrupt.
// - Defect register read-only flags, writable bit 7.
// - Operating mode fully writable, LOS enable bit 5.
// - Declare LOS on 32 zeros or line unit.
// - Clear LOS after 32 clean bits, unit clear.
module e3m_defect_monitor (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  input  wire logic        rx_line_clk,
  input  wire logic        rx_line_data,
  input  wire logic        liu_los,
  input  wire logic        lof_defect,
  input  wire logic        oof_defect,
  input  wire logic        rdi_defect,
  output logic             int_n,
  output logic             los_defect,
  output logic             ais_defect
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  localparam int SYNC_N = 3;

  logic [SYNC_N-1:0] sync_a_r;
  logic [SYNC_N-1:0] sync_b_r;
  logic [SYNC_N-1:0] pin_in;
  logic              line_clk_s;
  logic              line_data_s;
  logic              liu_los_s;
  logic              line_clk_d_r;
  logic [10:0]       frame_cnt_r;

  logic [7:0]        opmode_r;
  logic              lof_algo_r;
  logic [7:0]        int_mask_r;
  logic [`E3M_INT_NUM-1:0] int_stat_r;
  logic [`E3M_INT_NUM-1:0] int_evt;
  logic              los_prev_r;
  logic              ais_prev_r;
  logic              int_n_r;
  logic [7:0]        rdata_r;
  logic [7:0]        defect_view;
  logic [7:0]        int_view;
  logic              los_det;
  logic              ais_det;
  logic              g751_mode;

  e3m_pkg::e3m_reg_sel_e wr_sel;
  e3m_pkg::e3m_reg_sel_e rd_sel;
  logic              mask_wr;
  logic              mask_rd;

  e3m_bit_if bits ();

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic e3m_pkg::e3m_reg_sel_e reg_sel(input logic [15:0] addr);
    e3m_pkg::e3m_reg_sel_e sel;
    sel = e3m_pkg::e3m_sel_none;
    if (addr == `E3M_ADDR_OPMODE) begin
      sel = e3m_pkg::e3m_sel_opmode;
    end else if (addr == `E3M_ADDR_DEFECT) begin
      sel = e3m_pkg::e3m_sel_defect;
    end else if (addr == `E3M_ADDR_INT_STAT) begin
      sel = e3m_pkg::e3m_sel_int_stat;
    end
    return sel;
  endfunction

  assign wr_sel  = bus_wr ? reg_sel(bus_addr) : e3m_pkg::e3m_sel_none;
  assign rd_sel  = bus_rd ? reg_sel(bus_addr) : e3m_pkg::e3m_sel_none;
  assign mask_wr = bus_wr && (bus_addr == `E3M_ADDR_INT_MASK);
  assign mask_rd = bus_rd && (bus_addr == `E3M_ADDR_INT_MASK);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // The recovered clock is sampled like data; its rising edge marks a bit.
  assign pin_in = {liu_los, rx_line_data, rx_line_clk};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          sync_a_r[gi] <= 1'b0;
          sync_b_r[gi] <= 1'b0;
        end else begin
          sync_a_r[gi] <= pin_in[gi];
          sync_b_r[gi] <= sync_a_r[gi];
        end
      end
    end
  endgenerate

  assign line_clk_s  = sync_b_r[0];
  assign line_data_s = sync_b_r[1];
  assign liu_los_s   = sync_b_r[2];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      line_clk_d_r <= 1'b0;
    end else begin
      line_clk_d_r <= line_clk_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Bit strobe and frame period
  // ---------------------------------------------------------------------------
  // Frame periods are counted free from reset; alignment to the frame
  // pattern is not needed, since only the zero density of a period matters.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_cnt_r <= 11'h000;
    end else if (bits.bit_valid) begin
      if (bits.frame_end) begin
        frame_cnt_r <= 11'h000;
      end else begin
        frame_cnt_r <= frame_cnt_r + 11'h001;
      end
    end
  end

  assign bits.bit_valid = line_clk_s && !line_clk_d_r;
  assign bits.bit_data  = line_data_s;
  assign bits.frame_end = (frame_cnt_r == `E3M_FRAME_BITS - 11'h001);

  // ---------------------------------------------------------------------------
  // Defect detectors
  // ---------------------------------------------------------------------------
  assign g751_mode = !opmode_r[`E3M_OPM_DS3_SEL] &&
                     !opmode_r[`E3M_OPM_FRAME_FMT];

  e3m_los_det u_los (
    .mclk       (mclk),
    .rst        (rst),
    .bits       (bits.snk),
    .int_los_en (opmode_r[`E3M_OPM_INT_LOS_EN]),
    .liu_los    (liu_los_s),
    .los_defect (los_det)
  );

  e3m_ais_det u_ais (
    .mclk       (mclk),
    .rst        (rst),
    .bits       (bits.snk),
    .g751_mode  (g751_mode),
    .ais_defect (ais_det)
  );

  assign los_defect = los_det;
  assign ais_defect = ais_det;

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      opmode_r <= `E3M_OPMODE_RST;
    end else if (wr_sel == e3m_pkg::e3m_sel_opmode) begin
      opmode_r <= bus_wdata;
    end
  end

  // Only the loss-of-frame algorithm select in the defect register takes a
  // write; the flags beside it ignore writes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lof_algo_r <= `E3M_LOF_ALGO_RST;
    end else if (wr_sel == e3m_pkg::e3m_sel_defect) begin
      lof_algo_r <= bus_wdata[`E3M_DEF_LOF_ALGO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_mask_r <= `E3M_INT_MASK_RST;
    end else if (mask_wr) begin
      int_mask_r <= {6'h00, bus_wdata[`E3M_INT_NUM-1:0]};
    end
  end

  // ---------------------------------------------------------------------------
  // Change-of-condition interrupts
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      los_prev_r <= 1'b0;
      ais_prev_r <= 1'b0;
    end else begin
      los_prev_r <= los_det;
      ais_prev_r <= ais_det;
    end
  end

  // Both declaring and clearing a defect count as a change.
  assign int_evt[`E3M_INT_AIS] = ais_det != ais_prev_r;
  assign int_evt[`E3M_INT_LOS] = los_det != los_prev_r;

  // A change landing in the cycle of a read or a write-one clear stays set.
  generate
    for (gi = 0; gi < `E3M_INT_NUM; gi++) begin : g_int
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          int_stat_r[gi] <= 1'b0;
        end else if (int_evt[gi]) begin
          int_stat_r[gi] <= 1'b1;
        end else if (rd_sel == e3m_pkg::e3m_sel_int_stat) begin
          int_stat_r[gi] <= 1'b0;
        end else if (wr_sel == e3m_pkg::e3m_sel_int_stat &&
                     bus_wdata[gi]) begin
          int_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= !(|(int_stat_r & int_mask_r[`E3M_INT_NUM-1:0]));
    end
  end

  assign int_n = int_n_r;

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  always_comb begin
    defect_view                    = 8'h00;
    defect_view[`E3M_DEF_LOF_ALGO] = lof_algo_r;
    defect_view[`E3M_DEF_LOF]      = lof_defect;
    defect_view[`E3M_DEF_OOF]      = oof_defect;
    defect_view[`E3M_DEF_LOS]      = los_det;
    defect_view[`E3M_DEF_AIS]      = ais_det;
    defect_view[`E3M_DEF_RDI]      = rdi_defect;
    int_view                       = 8'h00;
    int_view[`E3M_INT_NUM-1:0]     = int_stat_r;
  end

  // Read data stand for exactly one cycle; unmapped addresses read zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (mask_rd) begin
      rdata_r <= int_mask_r;
    end else begin
      unique case (rd_sel)
        e3m_pkg::e3m_sel_opmode:   rdata_r <= opmode_r;
        e3m_pkg::e3m_sel_defect:   rdata_r <= defect_view;
        e3m_pkg::e3m_sel_int_stat: rdata_r <= int_view;
        e3m_pkg::e3m_sel_none:     rdata_r <= 8'h00;
      endcase
    end
  end

  assign bus_rdata = rdata_r;

endmodule

`default_nettype wire

// File: tb/e3m_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "e3m_consts.svh"

module e3m_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        rx_line_clk,
  input wire logic        rx_line_data,
  input wire logic        liu_los,
  input wire logic        lof_defect,
  input wire logic        oof_defect,
  input wire logic        rdi_defect,
  input wire logic        int_n,
  input wire logic        los_defect,
  input wire logic        ais_defect
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Shadows of the fields that software writes.
  // ----------------------------------------------------------------------
  logic [7:0] opm_r;
  logic [1:0] msk_r;
  logic       algo_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      opm_r  <= `E3M_OPMODE_RST;
      msk_r  <= 2'h3;
      algo_r <= `E3M_LOF_ALGO_RST;
    end else if (bus_wr) begin
      if (bus_addr == `E3M_ADDR_OPMODE) opm_r <= bus_wdata;
      if (bus_addr == `E3M_ADDR_INT_MASK) msk_r <= bus_wdata[1:0];
      if (bus_addr == `E3M_ADDR_DEFECT) algo_r <= bus_wdata[7];
    end
  end

  property p_rdata_idle;
    !$past(bus_rd) |-> bus_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
  property p_defect_rd;
    $past(bus_rd) && $past(bus_addr) == `E3M_ADDR_DEFECT |->
      bus_rdata == {$past(algo_r), $past(lof_defect), $past(oof_defect),
                    $past(los_defect), $past(ais_defect), 2'h0,
                    $past(rdi_defect)};
  endproperty
  a_defect_rd: assert property (p_defect_rd)
    else $error("defect register read wrong");
  property p_opm_rd;
    $past(bus_rd) && $past(bus_addr) == `E3M_ADDR_OPMODE |->
      bus_rdata == $past(opm_r);
  endproperty
  a_opm_rd: assert property (p_opm_rd)
    else $error("operating mode read wrong");
  property p_los_clr_int;
    $fell(los_defect) && msk_r[1] |-> ##[1:2] !int_n;
  endproperty
  a_los_clr_int: assert property (p_los_clr_int)
    else $error("no interrupt on signal loss clearing");
  property p_ais_set_int;
    $rose(ais_defect) && msk_r[0] |-> ##[1:2] !int_n;
  endproperty
  a_ais_set_int: assert property (p_ais_set_int)
    else $error("no interrupt on alarm declare");
  property p_ais_clr_int;
    $fell(ais_defect) && msk_r[0] |-> ##[1:2] !int_n;
  endproperty
  a_ais_clr_int: assert property (p_ais_clr_int)
    else $error("no interrupt on alarm clear");
  property p_los_liu;
    liu_los [*5] |-> los_defect;
  endproperty
  a_los_liu: assert property (p_los_liu)
    else $error("line unit loss not followed");
  property p_los_no_run;
    $rose(los_defect) && !opm_r[`E3M_OPM_INT_LOS_EN] |->
      $past(liu_los, 2) || $past(liu_los, 3) || $past(liu_los, 4);
  endproperty
  a_los_no_run: assert property (p_los_no_run)
    else $error("signal loss declared without line unit");
  property p_los_clr_liu;
    $fell(los_defect) |-> !$past(liu_los, 3);
  endproperty
  a_los_clr_liu: assert property (p_los_clr_liu)
    else $error("signal loss cleared while line unit declares");
  property p_rd_clear;
    bus_rd && bus_addr == `E3M_ADDR_INT_STAT && $stable(los_defect) &&
      $stable(ais_defect) ##1 $stable(los_defect) && $stable(ais_defect)
      |=> int_n;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("interrupt still low after status read");
endmodule

bind e3m_defect_monitor e3m_props props_u (.mclk, .rst, .bus_addr,
  .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .rx_line_clk, .rx_line_data,
  .liu_los, .lof_defect, .oof_defect, .rdi_defect, .int_n, .los_defect,
  .ais_defect);

`default_nettype wire

// File: tb/e3m_liu_model.sv
`timescale 1ns/1ns
`default_nettype none

// Line unit: one bit every 6 cycles, data launched on the falling edge.
module e3m_liu_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        next_bit,
  input  wire logic        los_req,
  output logic             rx_line_clk,
  output logic             rx_line_data,
  output logic             liu_los,
  output logic [31:0]      bit_cnt
);
  logic [2:0] div_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r        <= 3'h0;
      rx_line_clk  <= 1'b0;
      rx_line_data <= 1'b0;
      bit_cnt      <= 32'h0;
    end else if (!run) begin
      // Idle line: clock parked low, data wandering.
      div_r        <= 3'h0;
      rx_line_clk  <= 1'b0;
      rx_line_data <= ~rx_line_data;
    end else begin
      div_r <= (div_r == 3'h5) ? 3'h0 : div_r + 3'h1;
      if (div_r == 3'h0) begin
        rx_line_clk  <= 1'b0;
        rx_line_data <= next_bit;
        bit_cnt      <= bit_cnt + 32'h1;
      end
      if (div_r == 3'h3) rx_line_clk <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) liu_los <= 1'b0;
    else liu_los <= los_req;
  end
endmodule

`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "e3m_consts.svh"

module tb;
  logic        mclk;
  logic        rst;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_rdata;
  logic        rx_line_clk;
  logic        rx_line_data;
  logic        liu_los;
  logic        lof_defect;
  logic        oof_defect;
  logic        rdi_defect;
  logic        int_n;
  logic        los_defect;
  logic        ais_defect;
  logic        run;
  logic        los_req;
  logic        next_bit;
  logic [31:0] bit_cnt;
  logic [1:0]  dmode;
  logic [3:0]  nz;
  logic [7:0]  rnd;
  integer      seed = 32'h770ed2d3;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  e3m_defect_monitor dut_u (.mclk, .rst, .bus_addr, .bus_wdata, .bus_wr,
    .bus_rd, .bus_rdata, .rx_line_clk, .rx_line_data, .liu_los, .lof_defect,
    .oof_defect, .rdi_defect, .int_n, .los_defect, .ais_defect);
  e3m_liu_model liu_u (.mclk, .rst, .run, .next_bit, .los_req, .rx_line_clk,
    .rx_line_data, .liu_los, .bit_cnt);

  // ----------------------------------------------------------------------
  // Line pattern: ones with nz zeros at frame start, all zeros, or 1101.
  // ----------------------------------------------------------------------
  function automatic logic stim_bit(input logic [31:0] n,
                                    input logic [1:0] m, input logic [3:0] z);
    case (m)
      2'h0:    return (n % `E3M_FRAME_BITS) >= 32'(z);
      2'h1:    return 1'b0;
      default: return n[1:0] != 2'h2;
    endcase
  endfunction
  always_comb next_bit = stim_bit(bit_cnt, dmode, nz);

  function automatic logic [7:0] exp_def(input logic a, input logic [2:0] f,
                                         input logic los, input logic ais);
    return {a, f[2], f[1], los, ais, 2'h0, f[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge mclk);
    bus_wr    <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge mclk);
    bus_rd   <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic upto(input logic [31:0] n);
    while (bit_cnt < n) @(posedge mclk);
    repeat (12) @(posedge mclk);
    #1;
  endtask
  task automatic test_done;
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    rst = 1'b1;
    {bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
    {lof_defect, oof_defect, rdi_defect, run, los_req} = '0;
    dmode = 2'h1;
    nz = 4'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdc(`E3M_ADDR_OPMODE, `E3M_OPMODE_RST);
    rdc(`E3M_ADDR_INT_STAT, 8'h00);
    rdc(`E3M_ADDR_INT_MASK, `E3M_INT_MASK_RST);
    rdc(16'h1112, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = 8'($random(seed));
      {lof_defect, oof_defect, rdi_defect} <= rnd[2:0];
      wr(`E3M_ADDR_OPMODE, rnd);
      rdc(`E3M_ADDR_OPMODE, rnd);
      wr(`E3M_ADDR_DEFECT, ~rnd);
      rdc(`E3M_ADDR_DEFECT, exp_def(~rnd[7], rnd[2:0], 1'b0, 1'b0));
    end
    {lof_defect, oof_defect, rdi_defect} <= 3'h0;
    wr(`E3M_ADDR_OPMODE, `E3M_OPMODE_RST);
    wr(`E3M_ADDR_DEFECT, 8'h00);
    run <= 1'b1;
    upto(40);
    chk(8'(los_defect), 8'h00);
    wr(`E3M_ADDR_INT_MASK, 8'h00);
    los_req <= 1'b1;
    wt(8);
    chk(8'(los_defect), 8'h01);
    chk(8'(int_n), 8'h01);
    rdc(`E3M_ADDR_DEFECT, exp_def(1'b0, 3'h0, 1'b1, 1'b0));
    wr(`E3M_ADDR_INT_MASK, 8'h03);
    wt(3);
    chk(8'(int_n), 8'h00);
    rdc(`E3M_ADDR_INT_STAT, 8'h02);
    wt(2);
    chk(8'(int_n), 8'h01);
    los_req <= 1'b0;
    dmode <= 2'h2;
    wt(8);
    chk(8'(los_defect), 8'h01);
    upto(bit_cnt + 45);
    chk(8'(los_defect), 8'h00);
    chk(8'(int_n), 8'h00);
    rdc(`E3M_ADDR_INT_STAT, 8'h02);
    wr(`E3M_ADDR_OPMODE, `E3M_OPMODE_RST | 8'h20);
    dmode <= 2'h1;
    upto(bit_cnt + 20);
    chk(8'(los_defect), 8'h00);
    upto(bit_cnt + 16);
    chk(8'(los_defect), 8'h01);
    rdc(`E3M_ADDR_INT_STAT, 8'h02);
    dmode <= 2'h2;
    upto(bit_cnt + 45);
    chk(8'(los_defect), 8'h00);
    rdc(`E3M_ADDR_INT_STAT, 8'h02);
    dmode <= 2'h0;
    nz <= 4'h7;
    upto(1600);
    nz <= 4'h0;
    upto(3072);
    chk(8'(ais_defect), 8'h00);
    upto(3800);
    nz <= 4'h8;
    upto(4608);
    chk(8'(ais_defect), 8'h01);
    rdc(`E3M_ADDR_DEFECT, exp_def(1'b0, 3'h0, 1'b0, 1'b1));
    chk(8'(int_n), 8'h00);
    rdc(`E3M_ADDR_INT_STAT, 8'h01);
    upto(6144);
    chk(8'(ais_defect), 8'h01);
    upto(7680);
    chk(8'(ais_defect), 8'h00);
    rdc(`E3M_ADDR_DEFECT, 8'h00);
    chk(8'(int_n), 8'h00);
    rdc(`E3M_ADDR_INT_STAT, 8'h01);
    test_done();
  end
endmodule

`default_nettype wire
